// File: rtl/touch_key_unit.sv
// capacitive key measurement unit with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "touch_key_cfg.svh"
module touch_key_unit
   import touch_key_pkg::*;
#(
   parameter int UNIT_W = 5
) (
   input  wire logic                I_CLOCK,        // system clock, 100 MHz
   input  wire logic                I_RST_N,        // async reset, active low
   input  wire logic [`ADDR_W-1:0]  I_AWADDR,       // write address
   input  wire logic                I_AWVALID,      // write address valid
   output logic                     O_AWREADY,      // write address ready
   input  wire logic [31:0]         I_WDATA,        // write data
   input  wire logic [3:0]          I_WSTRB,        // write byte enables
   input  wire logic                I_WVALID,       // write data valid
   output logic                     O_WREADY,       // write data ready
   output logic [1:0]               O_BRESP,        // write response
   output logic                     O_BVALID,       // write response valid
   input  wire logic                I_BREADY,       // write response ready
   input  wire logic [`ADDR_W-1:0]  I_ARADDR,       // read address
   input  wire logic                I_ARVALID,      // read address valid
   output logic                     O_ARREADY,      // read address ready
   output logic [31:0]              O_RDATA,        // read data
   output logic [1:0]               O_RRESP,        // read response
   output logic                     O_RVALID,       // read data valid
   input  wire logic                I_RREADY,       // read data ready
   input  wire logic                I_REF_OSC_TICK, // one pulse per reference osc cycle
   input  wire logic [1:0]          I_KEY_OSC_TICK, // one pulse per pad osc cycle
   output logic                     O_REF_OSC_EN,   // reference oscillator run
   output logic                     O_KEY_OSC_EN,   // key oscillator run
   output logic [1:0]               O_OSC_FREQ_SEL, // oscillator band
   output logic [2:0]               O_HOP_SEL,      // hop frequency in use
   output logic                     O_FREQ_DOUBLE,  // key oscillator doubling
   output logic                     O_FILTER_EN,    // filter function enable
   output logic [1:0]               O_KEY_MUX_SEL,  // pad routed to the sense osc
   output logic [1:0]               O_PAD_EN,       // per pad enables
   output logic [9:0]               O_REF_CAP,      // reference capacitor code
   output logic                     O_TOUCH_IRQ     // flag and enable, to the controller
);

   ////////////////////////////////////////////////////////////////////////////
   generate
      if (UNIT_W < 1 || UNIT_W > 8) begin : g_bad_unit
         $error("UNIT_W must lie in 1..8");
      end
   endgenerate

   function automatic logic reg_hit(input logic [`ADDR_W-1:0] a);
      reg_hit = (a[1:0] == 2'h0) && (a[`ADDR_W-1:2] <= (`ADDR_W-2)'(`IDX_LAST));
   endfunction

   byte_type             preload_r;
   logic                 slot_ovf_r;
   logic                 start_r;
   logic                 start_prev_r;
   logic                 sense_ovf_r;
   logic                 func_ovf_r;
   fclk_sel_type         fclk_r;
   logic [1:0]           osc_freq_r;
   logic [9:0]           ref_cap_r;
   byte_type             ctrl_a_r;
   logic                 tss_r;
   logic                 roen_r;
   logic                 koen_r;
   logic [1:0]           pad_en_r;
   logic                 irq_flag_r;
   logic                 irq_en_r;
   logic                 run_r;
   logic [2:0]           div_r;
   logic [UNIT_W-1:0]    unit_r;
   logic [`SLOT_W-1:0]   slot_r;
   logic [`CNT_W-1:0]    sense_r;
   logic [`CNT_W-1:0]    func_r;
   logic [2:0]           hop_hw_r;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side
   logic                 aw_got_r;
   logic                 w_got_r;
   logic [`ADDR_W-1:0]   awaddr_r;
   logic [31:0]          wdata_r;
   logic                 wlane0_r;
   logic                 wr_do;
   logic                 wr_ok;
   logic [3:0]           wr_idx;

   assign wr_do  = aw_got_r && w_got_r && !O_BVALID;
   assign wr_ok  = wr_do && reg_hit(awaddr_r) && wlane0_r;
   assign wr_idx = awaddr_r[5:2];

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_AWREADY <= 1'b1;
         aw_got_r  <= 1'b0;
         awaddr_r  <= '0;
      end else if (I_AWVALID && O_AWREADY) begin
         O_AWREADY <= 1'b0;
         aw_got_r  <= 1'b1;
         awaddr_r  <= I_AWADDR;
      end else begin
         if (wr_do)
            aw_got_r <= 1'b0;
         if (O_BVALID && I_BREADY)
            O_AWREADY <= 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_WREADY <= 1'b1;
         w_got_r  <= 1'b0;
         wdata_r  <= '0;
         wlane0_r <= 1'b0;
      end else if (I_WVALID && O_WREADY) begin
         O_WREADY <= 1'b0;
         w_got_r  <= 1'b1;
         wdata_r  <= I_WDATA;
         wlane0_r <= I_WSTRB[0];
      end else begin
         if (wr_do)
            w_got_r <= 1'b0;
         if (O_BVALID && I_BREADY)
            O_WREADY <= 1'b1;
      end
   end

   // a write without lane 0 or to a hole is refused with SLVERR, nothing stored
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_BVALID <= 1'b0;
         O_BRESP  <= `RESP_OKAY;
      end else if (wr_do) begin
         O_BVALID <= 1'b1;
         O_BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (I_BREADY) begin
         O_BVALID <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side
   logic [31:0]          rd_word;

   always_comb begin
      rd_word = '0;
      unique case (I_ARADDR[5:2])
         `IDX_SLOT_PRELOAD: rd_word[7:0] = preload_r;
         `IDX_TOUCH_CTRL0:  rd_word[7:0] = {1'b0, slot_ovf_r, start_r, sense_ovf_r,
                                           func_ovf_r, 1'b0, fclk_r};
         `IDX_TOUCH_CTRL1:  rd_word[1:0] = osc_freq_r;
         `IDX_FUNC_LOW:     rd_word[7:0] = func_r[7:0];
         `IDX_FUNC_HIGH:    rd_word[7:0] = func_r[15:8];
         `IDX_SENSE_LOW:    rd_word[7:0] = sense_r[7:0];
         `IDX_SENSE_HIGH:   rd_word[7:0] = sense_r[15:8];
         `IDX_REFCAP_LOW:   rd_word[7:0] = ref_cap_r[7:0];
         `IDX_REFCAP_HIGH:  rd_word[1:0] = ref_cap_r[9:8];
         `IDX_MOD_CTRL_A:   rd_word[7:0] = ctrl_a_r;
         `IDX_MOD_CTRL_B:   rd_word[7:0] = {tss_r, 1'b0, roen_r, koen_r, 2'b00, pad_en_r};
         `IDX_IRQ_CTRL:     rd_word[7:0] = {2'b00, irq_flag_r, 2'b00, irq_en_r, 2'b00};
         default:           rd_word = '0;
      endcase
      if (!reg_hit(I_ARADDR))
         rd_word = '0;
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_ARREADY <= 1'b1;
         O_RVALID  <= 1'b0;
         O_RDATA   <= '0;
         O_RRESP   <= `RESP_OKAY;
      end else if (I_ARVALID && O_ARREADY) begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b1;
         O_RDATA   <= rd_word;
         O_RRESP   <= reg_hit(I_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
         O_RVALID  <= 1'b0;
         O_ARREADY <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // measurement timing
   logic                 start_rise;
   logic                 slot_tick;
   logic                 key_tick;
   logic                 func_tick;
   logic                 unit_wrap;
   logic                 slot_ovf_evt;
   logic                 sense_wrap;
   logic                 func_wrap;

   assign start_rise = start_r && !start_prev_r;
   // start low stops the slot counter at once, not one cycle after run falls
   assign slot_tick  = run_r && start_r
                       && (tss_r ? (div_r[1:0] == 2'h3) : (I_REF_OSC_TICK && roen_r));
   assign key_tick   = run_r && koen_r && pad_en_r[O_KEY_MUX_SEL[0]]
                       && !O_KEY_MUX_SEL[1] && I_KEY_OSC_TICK[O_KEY_MUX_SEL[0]];
   always_comb begin
      unique case (fclk_r)
         FCLK_DIV1: func_tick = run_r;
         FCLK_DIV2: func_tick = run_r && div_r[0];
         FCLK_DIV4: func_tick = run_r && (div_r[1:0] == 2'h3);
         FCLK_DIV8: func_tick = run_r && (div_r == 3'h7);
      endcase
   end
   assign unit_wrap    = slot_tick && (unit_r == {UNIT_W{1'b1}});
   assign slot_ovf_evt = unit_wrap && (slot_r == {`SLOT_W{1'b1}});
   assign sense_wrap   = key_tick && (sense_r == {`CNT_W{1'b1}});
   assign func_wrap    = func_tick && (func_r == {`CNT_W{1'b1}});

   // free running system clock prescaler
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N)
         div_r <= '0;
      else
         div_r <= div_r + 3'h1;
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         start_prev_r <= 1'b0;
         run_r        <= 1'b0;
      end else begin
         start_prev_r <= start_r;
         if (!start_r || slot_ovf_evt)
            run_r <= 1'b0;
         else if (start_rise)
            run_r <= 1'b1;
      end
   end

   // slot counter keeps its value while start is low
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         unit_r <= '0;
         slot_r <= '0;
      end else begin
         if (!start_r)
            unit_r <= '0;
         else if (slot_tick)
            unit_r <= unit_r + 1'b1;
         if (start_rise)
            slot_r <= preload_r;
         else if (unit_wrap)
            slot_r <= slot_r + 1'b1;
      end
   end

   // sense and function counters wrap and keep going until the window closes
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sense_r <= '0;
         func_r  <= '0;
      end else if (!start_r) begin
         sense_r <= '0;
         func_r  <= '0;
      end else begin
         if (key_tick)
            sense_r <= sense_r + 1'b1;
         if (func_tick)
            func_r <= func_r + 1'b1;
      end
   end

   // hardware hopping advances one step per window
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N)
         hop_hw_r <= '0;
      else if (start_rise)
         hop_hw_r <= hop_hw_r + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers; hardware set wins over a clear in the same cycle
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         slot_ovf_r  <= 1'b0;
         start_r     <= 1'b0;
         sense_ovf_r <= 1'b0;
         func_ovf_r  <= 1'b0;
         fclk_r      <= FCLK_DIV1;
      end else begin
         if (wr_ok && wr_idx == `IDX_TOUCH_CTRL0) begin
            slot_ovf_r  <= wdata_r[`B_SLOT_OVF];
            start_r     <= wdata_r[`B_START];
            sense_ovf_r <= wdata_r[`B_SENSE_OVF];
            func_ovf_r  <= wdata_r[`B_FUNC_OVF];
            fclk_r      <= fclk_sel_type'(wdata_r[1:0]);
         end
         if (slot_ovf_evt)
            slot_ovf_r <= 1'b1;
         if (sense_wrap)
            sense_ovf_r <= 1'b1;
         if (func_wrap)
            func_ovf_r <= 1'b1;
      end
   end

   // a software write of the overflow flag leaves the request flag alone
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         irq_flag_r <= 1'b0;
         irq_en_r   <= 1'b0;
      end else begin
         if (wr_ok && wr_idx == `IDX_IRQ_CTRL) begin
            irq_flag_r <= wdata_r[`B_IRQ_FLAG];
            irq_en_r   <= wdata_r[`B_IRQ_EN];
         end
         if (slot_ovf_evt)
            irq_flag_r <= 1'b1;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         preload_r  <= '0;
         osc_freq_r <= `OSC_FREQ_RST;
         ref_cap_r  <= '0;
         ctrl_a_r   <= '0;
         tss_r      <= 1'b0;
         roen_r     <= 1'b0;
         koen_r     <= 1'b0;
         pad_en_r   <= '0;
      end else if (wr_ok) begin
         unique case (wr_idx)
            `IDX_SLOT_PRELOAD: preload_r <= wdata_r[7:0];
            `IDX_TOUCH_CTRL1:  osc_freq_r <= wdata_r[1:0];
            `IDX_REFCAP_LOW:   ref_cap_r[7:0] <= wdata_r[7:0];
            `IDX_REFCAP_HIGH:  ref_cap_r[9:8] <= wdata_r[1:0];
            `IDX_MOD_CTRL_A:   ctrl_a_r <= wdata_r[7:0];
            `IDX_MOD_CTRL_B: begin
               tss_r    <= wdata_r[`B_TSS];
               roen_r   <= wdata_r[`B_ROEN];
               koen_r   <= wdata_r[`B_KOEN];
               pad_en_r <= wdata_r[1:0];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls, all registered
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_REF_OSC_EN   <= 1'b0;
         O_KEY_OSC_EN   <= 1'b0;
         O_OSC_FREQ_SEL <= `OSC_FREQ_RST;
         O_HOP_SEL      <= '0;
         O_FREQ_DOUBLE  <= 1'b0;
         O_FILTER_EN    <= 1'b0;
         O_KEY_MUX_SEL  <= MUX_PAD_ONE;
         O_PAD_EN       <= '0;
         O_REF_CAP      <= '0;
         O_TOUCH_IRQ    <= 1'b0;
      end else begin
         // oscillators only run inside a window
         O_REF_OSC_EN   <= roen_r && (run_r || start_rise) && !slot_ovf_evt;
         O_KEY_OSC_EN   <= koen_r && (run_r || start_rise) && !slot_ovf_evt;
         O_OSC_FREQ_SEL <= osc_freq_r;
         O_HOP_SEL      <= ctrl_a_r[`B_HOPHW] ? hop_hw_r : ctrl_a_r[2:0];
         O_FREQ_DOUBLE  <= ctrl_a_r[`B_FDBL];
         O_FILTER_EN    <= ctrl_a_r[`B_FILT];
         O_KEY_MUX_SEL  <= ctrl_a_r[7:6];
         O_PAD_EN       <= pad_en_r;
         O_REF_CAP      <= ref_cap_r;
         O_TOUCH_IRQ    <= irq_flag_r && irq_en_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_window_end: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      run_r |=> slot_r == $past(slot_r) + `SLOT_W'($past(unit_wrap)))
      else $error("slot counter stepped off a unit period boundary");
   a_ovf_effects: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      slot_ovf_evt |=> slot_ovf_r && irq_flag_r && !run_r ##1 !O_REF_OSC_EN && !O_KEY_OSC_EN)
      else $error("slot overflow did not flag and stop");
   a_counts_held: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      slot_ovf_evt ##1 start_r |=> $stable(sense_r) && $stable(func_r) && $stable(slot_r))
      else $error("counters moved after the window closed");
   a_sw_no_irq: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      wr_ok && wr_idx == `IDX_TOUCH_CTRL0 && !irq_flag_r && !slot_ovf_evt |=> !irq_flag_r)
      else $error("software flag write raised the request");
   a_stop_clears: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      !start_r |=> sense_r == '0 && func_r == '0 && unit_r == '0 && slot_r == $past(slot_r))
      else $error("stopped counters not cleared or slot counter disturbed");
   a_start_load: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      start_rise |=> run_r && slot_r == $past(preload_r) ##1 (O_REF_OSC_EN == roen_r))
      else $error("start edge did not open the window");
   a_sense_wrap: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      sense_wrap |=> sense_ovf_r && sense_r == '0)
      else $error("sense counter wrap not flagged");
   a_func_wrap: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      func_wrap |=> func_ovf_r && func_r == '0)
      else $error("function counter wrap not flagged");
   a_func_rate: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      run_r && start_r && fclk_r == FCLK_DIV8 && $stable(fclk_r) && !slot_ovf_evt
      && func_r != {`CNT_W{1'b1}} |=> func_r - $past(func_r) == `CNT_W'(div_r == 3'h0))
      else $error("function counter rate wrong at divide by eight");
   a_rsvd_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
      O_RVALID |-> O_RDATA[31:8] == '0)
      else $error("unimplemented read bits not zero");

endmodule

// File: rtl/touch_key_cfg.svh
// register map, field positions and reset values of the touch key measurement unit
`ifndef TOUCH_KEY_CFG_SVH
`define TOUCH_KEY_CFG_SVH
`define IDX_SLOT_PRELOAD  4'h0
`define IDX_TOUCH_CTRL0   4'h1
`define IDX_TOUCH_CTRL1   4'h2
`define IDX_FUNC_LOW      4'h3
`define IDX_FUNC_HIGH     4'h4
`define IDX_SENSE_LOW     4'h5
`define IDX_SENSE_HIGH    4'h6
`define IDX_REFCAP_LOW    4'h7
`define IDX_REFCAP_HIGH   4'h8
`define IDX_MOD_CTRL_A    4'h9
`define IDX_MOD_CTRL_B    4'hA
`define IDX_IRQ_CTRL      4'hB
`define IDX_LAST          4'hB
`define ADDR_W            12
`define CNT_W             16
`define SLOT_W            8
`define B_SLOT_OVF        6
`define B_START           5
`define B_SENSE_OVF       4
`define B_FUNC_OVF        3
`define B_IRQ_FLAG        5
`define B_IRQ_EN          2
`define B_TSS             7
`define B_ROEN            5
`define B_KOEN            4
`define B_FDBL            5
`define B_FILT            4
`define B_HOPHW           3
`define OSC_FREQ_RST      2'h3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// File: rtl/touch_key_pkg.sv
// types shared by the touch key measurement unit
package touch_key_pkg;
   typedef logic [7:0] byte_type;
   typedef enum logic [1:0] {
      FCLK_DIV1 = 2'b00,
      FCLK_DIV2 = 2'b01,
      FCLK_DIV4 = 2'b10,
      FCLK_DIV8 = 2'b11
   } fclk_sel_type;
   typedef enum logic [1:0] {
      MUX_PAD_ONE = 2'b00,
      MUX_PAD_TWO = 2'b01,
      MUX_RSVD_A  = 2'b10,
      MUX_RSVD_B  = 2'b11
   } key_mux_type;
endpackage

// File: test/test_touch_key_unit.sv
// self-checking bench of the touch key measurement unit
`timescale 1ns/1ps
`include "touch_key_cfg.svh"
module test_touch_key_unit
   import touch_key_pkg::*;
;
   localparam int UW = 7;
   logic              full = 0;
   logic              clk = 0, rst_n = 0;
   logic [11:0]       awaddr = 0, araddr = 0;
   logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0]       wdata = 0, rdata, rv;
   logic [3:0]        wstrb = 0;
   logic              ref_tick = 0, awready, wready, bvalid, arready, rvalid;
   logic [1:0]        key_tick = 0, bresp, rresp, rs, freq, mux, pad;
   logic              ref_en, key_en, fdbl, filt, irq;
   logic [2:0]        hop;
   logic [9:0]        rcap;
   logic [7:0]        v [12];
   logic [15:0]       f;
   int                err_count = 0, num_checks = 0;

   touch_key_unit #(.UNIT_W(UW)) dut (
      .I_CLOCK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_REF_OSC_TICK(ref_tick),
      .I_KEY_OSC_TICK(key_tick), .O_REF_OSC_EN(ref_en), .O_KEY_OSC_EN(key_en),
      .O_OSC_FREQ_SEL(freq), .O_HOP_SEL(hop), .O_FREQ_DOUBLE(fdbl), .O_FILTER_EN(filt),
      .O_KEY_MUX_SEL(mux), .O_PAD_EN(pad), .O_REF_CAP(rcap), .O_TOUCH_IRQ(irq));

   always #5 clk = ~clk;
   // oscillator ticks are random pulses, or one every clock while full is set; the unit gates them itself
   always @(posedge clk) begin
      ref_tick <= full | 1'($urandom);
      key_tick <= {2{full}} | 2'($urandom);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task stop_test;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task tmo(input int n);
      if (n > 200) begin
         err_count++;
         stop_test();
      end
   endtask

   // entry waits an edge so a strobe is never lowered and raised in one step
   task wr(input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'hF;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         tmo(++n);
      end while (!bvalid);
      bready <= 0;
      rs = bresp;
   endtask

   task rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 0;
         tmo(++n);
      end while (!rvalid);
      rready <= 0;
      rv = rdata;
      rs = rresp;
   endtask

   // poll the slot overflow flag, bounded by a number of reads
   task wait_ovf(input int lim);
      int n;
      n = 0;
      do begin
         rd(12'h004);
         n++;
         if (n > lim) tmo(999);
      end while (!rv[6]);
   endtask

   task rd16(input logic [11:0] a);
      rd(a);
      f[7:0] = rv[7:0];
      rd(a + 12'h4);
      f[15:8] = rv[7:0];
   endtask

   function automatic logic [7:0] msk(input int i);
      case (i)
         1: msk = 8'h7B;
         2, 8: msk = 8'h03;
         10: msk = 8'hB3;
         11: msk = 8'h24;
         3, 4, 5, 6: msk = 8'h00;
         default: msk = 8'hFF;
      endcase
   endfunction

   // window = (256 - preload) units of 2**UW slot ticks, t clocks per slot tick
   function automatic logic inwin(input logic [31:0] c, input int s, input int p, input int t);
      int w;
      w = (256 - p) * (1 << UW) * t;
      inwin = (c >= ((w - 5) >> s)) && (c <= ((w + 5) >> s) + 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int idx [8] = '{0, 2, 7, 8, 9, 10, 11, 3};
      void'($urandom(28));
      repeat (4) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk(freq, 3);
      for (int i = 0; i < 12; i++) begin
         rd(12'(i * 4));
         chk(rv, (i == 2) ? 32'h3 : 32'h0);
      end
      rd(12'h030);
      chk({rv[7:0], rs}, 10'h2);
      rd(12'h006);
      chk(rs, 2);
      foreach (idx[k]) begin
         v[idx[k]] = 8'($urandom);
         wr(12'(idx[k] * 4), v[idx[k]]);
         rd(12'(idx[k] * 4));
         chk(rv, {24'h0, v[idx[k]] & msk(idx[k])});
      end
      repeat (2) @(posedge clk);
      chk(rcap, {v[8][1:0], v[7]});
      chk(pad, v[10][1:0]);
      wr(12'h024, 8'hA5);
      repeat (2) @(posedge clk);
      chk({mux, fdbl, filt, hop}, {MUX_RSVD_A, 1'b1, 1'b0, 3'h5});
      wr(12'h024, 8'h10);
      repeat (2) @(posedge clk);
      chk({mux, fdbl, filt, hop}, 7'h08);
      wr(12'h028, 8'hB1);
      wr(12'h000, 8'hFE);
      wr(12'h02C, 8'h04);
      for (int s = 0; s < 4; s++) begin
         wr(12'h004, 8'(s));
         wr(12'h004, 8'(8'h20 | s));
         if (s == 0) begin
            @(negedge clk);
            chk({ref_en, key_en}, 2'b11);
         end
         wait_ovf(400);
         rd16(12'h00C);
         chk(inwin(f, s, 8'hFE, 4), 1);
         if (s == 0) begin
            chk({irq, ref_en, key_en}, 3'b100);
            rd(12'h02C);
            chk(rv, 32'h24);
            repeat (10) @(posedge clk);
            rd(12'h00C);
            chk(rv[7:0], f[7:0]);
         end
      end
      // long window, ticks forced every clock so both 16-bit counters wrap
      full <= 1;
      wr(12'h000, 8'h7F);
      wr(12'h004, 8'h00);
      wr(12'h004, 8'h20);
      wait_ovf(23000);
      chk(rv[4:3], 2'b11);
      rd16(12'h00C);
      chk(inwin(32'h10000 + f, 0, 8'h7F, 4), 1);
      rd16(12'h014);
      chk(inwin(32'h10000 + f, 0, 8'h7F, 4), 1);
      // reference oscillator as slot clock, one tick per clock
      wr(12'h028, 8'h31);
      wr(12'h000, 8'hFE);
      wr(12'h004, 8'h00);
      wr(12'h004, 8'h20);
      wait_ovf(400);
      rd16(12'h00C);
      chk(inwin(f, 0, 8'hFE, 1), 1);
      full <= 0;
      wr(12'h004, 8'h00);
      rd(12'h00C);
      chk(rv, 0);
      rd(12'h014);
      chk(rv, 0);
      wr(12'h02C, 8'h04);
      wr(12'h004, 8'h40);
      rd(12'h02C);
      chk(rv, 32'h04);
      chk(irq, 0);
      // hardware hopping: six windows started so far, hop select 7 ignored
      wr(12'h024, 8'h0F);
      repeat (2) @(posedge clk);
      chk(hop, 3'h6);
      stop_test();
   end
endmodule
